/* hw/fac_ctrl.sv */
// Purpose: Fast acquisition controller with feedback phase offset
// Assumes: Loop signals come from logic on the same clock
// Notes: Bandwidth leaves as a power-of-two exponent over the final
//        loop bandwidth; the loop filter applies the scaling itself
//
// Contract
// - Enabled only while excess parameter nonzero
// - Start bandwidth is final times two-power
// - Halve bandwidth per settled lock until final
// - Settle field selects 1 ms..50 s
// - Advance after lock held whole settle
// - Lock drop restarts the settle timer
// - Timeout field selects 10 ms..100 s
// - Timeout advances to next step anyway
// - Final step settled sets complete bit
// - Zero triggers: fast on every acquisition
// - Trigger bit0: closed loop from freerun
// - Trigger bit1: closed loop from holdover
// - Trigger bit2: complete bit still zero
// - Self-clearing bit clears complete status
// - Trigger bit3: no distribution outputs toggling
// - Any met trigger runs fast, else normal
// - Signed 40-bit ps offset at feedback
// - Positive offset delays output edges
// - Skew and delay compensation summed too
// - In-progress bit high while sequence runs
// - Latched start and end flags, software cleared
`timescale 1ns/100ps
`default_nettype none
module fac_ctrl #(
    parameter int TICK_CYCLES = fac_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [fac_pkg::ADDR_W-1:0] addr,
    input wire logic [fac_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [fac_pkg::DATA_W-1:0] rdata,
    input wire logic phase_lock,
    input wire logic acq_enter,
    input wire logic acq_from_freerun,
    input wire logic acq_from_holdover,
    input wire logic outputs_toggling,
    input wire logic [fac_pkg::OFS_W-1:0] skew_offset,
    input wire logic [fac_pkg::OFS_W-1:0] delay_comp_offset,
    output logic [fac_pkg::EXP_W-1:0] bw_exponent,
    output logic fast_active,
    output logic [fac_pkg::SUM_W-1:0] fb_offset_sum
);
    ////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        fac_pkg::fac_state_e st;
        logic [fac_pkg::OFS_W-1:0] phase_ofs;
        logic [fac_pkg::EXP_W-1:0] trig;
        logic [fac_pkg::EXP_W-1:0] excess;
        logic [fac_pkg::TIMING_W-1:0] timing;
        logic done;
        logic busy;
        logic evt_start;
        logic evt_end;
        logic step_clr;
        logic [fac_pkg::EXP_W-1:0] bw_exp;
        logic [fac_pkg::DATA_W-1:0] rdata;
        logic [fac_pkg::SUM_W-1:0] fb_sum;
    } fac_ctrl_s;

    fac_ctrl_s s_r;
    fac_ctrl_s s_nxt;

    logic tick;
    logic settle_done;
    logic tmo_done;
    logic settle_clr;
    logic settle_run;
    logic [fac_pkg::MS_W-1:0] settle_lim;
    logic [fac_pkg::MS_W-1:0] tmo_lim;

    ////////////////////////////////////////////////////////////////////
    // Timebase and step timers

    fac_tick #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    assign settle_lim = fac_pkg::fac_settle_ms(
        s_r.timing[fac_pkg::SETTLE_LSB +: fac_pkg::SEL_W]);
    assign tmo_lim = fac_pkg::fac_timeout_ms(
        s_r.timing[fac_pkg::TIMEOUT_LSB +: fac_pkg::SEL_W]);

    assign settle_clr = s_r.step_clr || !phase_lock;
    assign settle_run = s_r.busy && phase_lock;

    // settle timer, ms tick, per-step clear
    fac_timer u_settle (
        .clk(clk),
        .rstn(rstn),
        .tick(tick),
        .clear(settle_clr),
        .run(settle_run),
        .limit(settle_lim),
        .done(settle_done)
    );

    fac_timer u_timeout (
        .clk(clk),
        .rstn(rstn),
        .tick(tick),
        .clear(s_r.step_clr),
        .run(s_r.busy),
        .limit(tmo_lim),
        .done(tmo_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Next-state logic

    always_comb begin
        logic en;
        logic hit;
        logic clr_done;
        logic clr_start;
        logic clr_end;
        logic [fac_pkg::IDX_W-1:0] idx;
        logic [fac_pkg::ADDR_W-1:0] rel;
        en = 1'b0;
        hit = 1'b0;
        clr_done = 1'b0;
        clr_start = 1'b0;
        clr_end = 1'b0;
        idx = '0;
        rel = '0;
        s_nxt = s_r;
        s_nxt.step_clr = 1'b0;
        s_nxt.rdata = '0;

        // Register writes
        if (wr) begin
            if (addr >= fac_pkg::A_PHASE_OFS_LO && addr <= fac_pkg::A_PHASE_OFS_HI) begin
                rel = addr - fac_pkg::A_PHASE_OFS_LO;
                idx = rel[fac_pkg::IDX_W-1:0];
                // Low byte sits at the lowest address
                s_nxt.phase_ofs[idx*fac_pkg::DATA_W +: fac_pkg::DATA_W] = wdata;
            end
            case (addr)
                fac_pkg::A_TRIG_SEL: begin
                    s_nxt.trig = wdata[fac_pkg::EXP_W-1:0];
                end
                fac_pkg::A_CMPL_CLR: begin
                    clr_done = wdata[fac_pkg::CMPL_CLR_BIT];
                end
                fac_pkg::A_EVT_CLR: begin
                    clr_start = wdata[fac_pkg::EVT_START_BIT];
                    clr_end = wdata[fac_pkg::EVT_END_BIT];
                end
                fac_pkg::A_PROF_EXCESS: begin
                    s_nxt.excess = wdata[fac_pkg::EXP_W-1:0];
                end
                fac_pkg::A_PROF_TIMING: begin
                    s_nxt.timing = wdata[fac_pkg::TIMING_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Clears go first so a same-cycle set overrides them
        if (clr_done) begin
            s_nxt.done = 1'b0;
        end
        if (clr_start) begin
            s_nxt.evt_start = 1'b0;
        end
        if (clr_end) begin
            s_nxt.evt_end = 1'b0;
        end

        // feature on only with nonzero excess
        en = (s_r.excess != '0);
        hit = (s_r.trig == '0)
            || (s_r.trig[fac_pkg::TRIG_FREERUN] && acq_from_freerun)
            || (s_r.trig[fac_pkg::TRIG_HOLDOVER] && acq_from_holdover)
            || (s_r.trig[fac_pkg::TRIG_FIRST] && !s_r.done)
            || (s_r.trig[fac_pkg::TRIG_NO_OUT] && !outputs_toggling);

        // Sequencer
        case (s_r.st)
            fac_pkg::FAC_IDLE: begin
                s_nxt.bw_exp = '0;
            end
            fac_pkg::FAC_RUN: begin
                if (!en) begin
                    s_nxt.st = fac_pkg::FAC_IDLE;
                    s_nxt.bw_exp = '0;
                end else if (!s_r.step_clr && (settle_done || tmo_done)) begin
                    if (s_r.bw_exp == '0) begin
                        s_nxt.st = fac_pkg::FAC_IDLE;
                        if (settle_done) begin
                            s_nxt.done = 1'b1;
                        end
                    end else begin
                        s_nxt.bw_exp = s_r.bw_exp - 4'h1;
                        s_nxt.step_clr = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.st = fac_pkg::FAC_IDLE;
            end
        endcase

        // New acquisition restarts the sequence or runs normally
        if (acq_enter) begin
            // any met trigger selects fast mode
            if (en && hit) begin
                s_nxt.st = fac_pkg::FAC_RUN;
                // start at final bandwidth times 2^excess
                s_nxt.bw_exp = s_r.excess;
                s_nxt.step_clr = 1'b1;
            end else begin
                s_nxt.st = fac_pkg::FAC_IDLE;
                s_nxt.bw_exp = '0;
            end
        end

        s_nxt.busy = (s_nxt.st == fac_pkg::FAC_RUN);
        // latch both edges of the busy bit
        if (s_nxt.busy && !s_r.busy) begin
            s_nxt.evt_start = 1'b1;
        end
        if (!s_nxt.busy && s_r.busy) begin
            s_nxt.evt_end = 1'b1;
        end

        // positive pushes feedback later, delaying output
        // skew and delay compensation join the sum
        s_nxt.fb_sum = {{2{s_r.phase_ofs[fac_pkg::OFS_W-1]}}, s_r.phase_ofs}
            + {{2{skew_offset[fac_pkg::OFS_W-1]}}, skew_offset}
            + {{2{delay_comp_offset[fac_pkg::OFS_W-1]}}, delay_comp_offset};

        // Register reads; data only in the cycle after the strobe
        if (rd) begin
            if (addr >= fac_pkg::A_PHASE_OFS_LO && addr <= fac_pkg::A_PHASE_OFS_HI) begin
                rel = addr - fac_pkg::A_PHASE_OFS_LO;
                idx = rel[fac_pkg::IDX_W-1:0];
                s_nxt.rdata = s_r.phase_ofs[idx*fac_pkg::DATA_W +: fac_pkg::DATA_W];
            end
            case (addr)
                fac_pkg::A_TRIG_SEL: begin
                    s_nxt.rdata[fac_pkg::EXP_W-1:0] = s_r.trig;
                end
                fac_pkg::A_LOOP_STAT2: begin
                    s_nxt.rdata[fac_pkg::STAT_BUSY_BIT] = s_r.busy;
                    s_nxt.rdata[fac_pkg::STAT_DONE_BIT] = s_r.done;
                end
                fac_pkg::A_EVT_STAT: begin
                    s_nxt.rdata[fac_pkg::EVT_START_BIT] = s_r.evt_start;
                    s_nxt.rdata[fac_pkg::EVT_END_BIT] = s_r.evt_end;
                end
                fac_pkg::A_PROF_EXCESS: begin
                    s_nxt.rdata[fac_pkg::EXP_W-1:0] = s_r.excess;
                end
                fac_pkg::A_PROF_TIMING: begin
                    s_nxt.rdata[fac_pkg::TIMING_W-1:0] = s_r.timing;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State register

    // Synchronous reset; phase offset starts at zero
    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign rdata = s_r.rdata;
    assign bw_exponent = s_r.bw_exp;
    assign fast_active = s_r.busy;
    assign fb_offset_sum = s_r.fb_sum;
endmodule : fac_ctrl
`default_nettype wire

/* common/fac_pkg.sv */
// Purpose: Shared constants for the fast acquisition controller
// Assumes: 8-bit register port, 16-bit byte addresses, 50 MHz clock
// Notes: Durations are kept in milliseconds and counted on a 1 ms tick
`default_nettype none
package fac_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int OFS_W = 40;
    localparam int SUM_W = 42;
    localparam int MS_W = 17;
    localparam int EXP_W = 4;
    localparam int OFS_BYTES = 5;
    localparam int IDX_W = 3;

    ////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [15:0] A_PHASE_OFS_LO = 16'h1015;
    localparam logic [15:0] A_PHASE_OFS_HI = 16'h1019;
    localparam logic [15:0] A_TRIG_SEL = 16'h2106;
    localparam logic [15:0] A_CMPL_CLR = 16'h2107;
    localparam logic [15:0] A_EVT_CLR = 16'h200D;
    localparam logic [15:0] A_LOOP_STAT2 = 16'h3102;
    localparam logic [15:0] A_EVT_STAT = 16'h3012;
    localparam logic [15:0] A_PROF_EXCESS = 16'h0116;
    localparam logic [15:0] A_PROF_TIMING = 16'h0117;

    // Field positions
    localparam int TRIG_FREERUN = 0;
    localparam int TRIG_HOLDOVER = 1;
    localparam int TRIG_FIRST = 2;
    localparam int TRIG_NO_OUT = 3;
    localparam int CMPL_CLR_BIT = 3;
    localparam int EVT_START_BIT = 2;
    localparam int EVT_END_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_DONE_BIT = 5;
    localparam int SETTLE_LSB = 0;
    localparam int TIMEOUT_LSB = 4;
    localparam int SEL_W = 3;
    localparam int TIMING_W = 7;

    ////////////////////////////////////////////////////////////////////
    // Timebase
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_NS = 1_000_000;
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic {FAC_IDLE, FAC_RUN} fac_state_e;

    // Settle time in ms: 1,10,50,100,500,1000,10000,50000
    function automatic logic [MS_W-1:0] fac_settle_ms(input logic [SEL_W-1:0] sel);
        case (sel)
            3'h0: fac_settle_ms = 17'h0_0001;
            3'h1: fac_settle_ms = 17'h0_000A;
            3'h2: fac_settle_ms = 17'h0_0032;
            3'h3: fac_settle_ms = 17'h0_0064;
            3'h4: fac_settle_ms = 17'h0_01F4;
            3'h5: fac_settle_ms = 17'h0_03E8;
            3'h6: fac_settle_ms = 17'h0_2710;
            default: fac_settle_ms = 17'h0_C350;
        endcase
    endfunction : fac_settle_ms

    // Timeout in ms: 10,50,100,500,1000,10000,50000,100000
    function automatic logic [MS_W-1:0] fac_timeout_ms(input logic [SEL_W-1:0] sel);
        case (sel)
            3'h0: fac_timeout_ms = 17'h0_000A;
            3'h1: fac_timeout_ms = 17'h0_0032;
            3'h2: fac_timeout_ms = 17'h0_0064;
            3'h3: fac_timeout_ms = 17'h0_01F4;
            3'h4: fac_timeout_ms = 17'h0_03E8;
            3'h5: fac_timeout_ms = 17'h0_2710;
            3'h6: fac_timeout_ms = 17'h0_C350;
            default: fac_timeout_ms = 17'h1_86A0;
        endcase
    endfunction : fac_timeout_ms
endpackage : fac_pkg
`default_nettype wire

/* hw/fac_tick.sv */
// Purpose: One-cycle enable pulse every millisecond
// Assumes: CYCLES is at least two
// Notes: Shorten CYCLES in simulation
`timescale 1ns/100ps
`default_nettype none
module fac_tick #(
    parameter int CYCLES = fac_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } fac_tick_s;
    fac_tick_s s_r;
    fac_tick_s s_nxt;

    // Free running divider
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.cnt == 32'(CYCLES - 1)) begin
            s_nxt.cnt = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;
endmodule : fac_tick
`default_nettype wire

/* hw/fac_timer.sv */
// Purpose: Millisecond counter that flags when a limit is reached
// Assumes: limit is at least one
// Notes: Flag holds until clear
`timescale 1ns/100ps
`default_nettype none
module fac_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic clear,
    input wire logic run,
    input wire logic [fac_pkg::MS_W-1:0] limit,
    output logic done
);
    typedef struct packed {
        logic [fac_pkg::MS_W-1:0] cnt;
        logic done;
    } fac_timer_s;
    fac_timer_s s_r;
    fac_timer_s s_nxt;

    // Clear beats counting
    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt = '0;
        end else if (run && tick && !s_r.done) begin
            s_nxt.cnt = s_r.cnt + 17'h0_0001;
            s_nxt.done = (s_nxt.cnt >= limit);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
endmodule : fac_timer
`default_nettype wire

/* dv/fac_ctrl_monitor.sv */
// Purpose: Port-level checks on the fast acquisition controller
// Assumes: One clock domain, synchronous active-low reset
// Notes: Phase offset is shadowed from bus writes to predict the sum
`timescale 1ns/100ps
`default_nettype none
module fac_ctrl_monitor #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [fac_pkg::ADDR_W-1:0] addr,
    input wire logic [fac_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [fac_pkg::DATA_W-1:0] rdata,
    input wire logic phase_lock,
    input wire logic acq_enter,
    input wire logic acq_from_freerun,
    input wire logic acq_from_holdover,
    input wire logic outputs_toggling,
    input wire logic [fac_pkg::OFS_W-1:0] skew_offset,
    input wire logic [fac_pkg::OFS_W-1:0] delay_comp_offset,
    input wire logic [fac_pkg::EXP_W-1:0] bw_exponent,
    input wire logic fast_active,
    input wire logic [fac_pkg::SUM_W-1:0] fb_offset_sum
);
    logic [fac_pkg::OFS_W-1:0] ofs_r;
    logic [fac_pkg::OFS_W-1:0] ofs_nxt;
    logic [fac_pkg::SUM_W-1:0] sum_exp;
    ////////////////////////////////////////////////////////////////////
    // Shadow offset, each byte takes effect alone
    always_comb begin
        ofs_nxt = ofs_r;
        for (int i = 0; i < fac_pkg::OFS_BYTES; i++) begin
            if (wr && addr == fac_pkg::A_PHASE_OFS_LO + 16'(i)) begin
                ofs_nxt[8*i +: 8] = wdata;
            end
        end
    end
    always_ff @(posedge clk) begin
        ofs_r <= rstn ? ofs_nxt : '0;
    end
    // Sign-extended so negative offsets stay negative
    assign sum_exp = fac_pkg::SUM_W'($signed(ofs_r)) + fac_pkg::SUM_W'($signed(skew_offset))
        + fac_pkg::SUM_W'($signed(delay_comp_offset));
    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data seen outside answer cycle");
    AST_STAT_READ: assert property ($past(rd) && $past(addr) == fac_pkg::A_LOOP_STAT2 |->
        rdata[4] == $past(fast_active) && {rdata[7:6], rdata[3:0]} == 6'h00)
        else $error("busy status bit disagrees with fast_active");
    AST_CMPL_SELFCLR: assert property ($past(rd) && $past(addr) == fac_pkg::A_CMPL_CLR |->
        rdata == 8'h00) else $error("complete clear bit did not read back zero");
    AST_ACQ_RESP: assert property (acq_enter |=> fast_active == (bw_exponent != 4'h0))
        else $error("acquisition answer inconsistent");
    AST_START_CAUSE: assert property ($rose(fast_active) |-> $past(acq_enter))
        else $error("fast sequence began without acquisition entry");
    AST_STEP_HALVE: assert property ($past(fast_active) && fast_active && !$past(acq_enter)
        && $changed(bw_exponent) |-> bw_exponent == $past(bw_exponent) - 4'h1)
        else $error("bandwidth step not a single halving");
    // A reset that lands mid-sequence is not an early end
    AST_END_FINAL: assert property ($past(rstn) && $fell(fast_active)
        && !$past(acq_enter) |-> $past(bw_exponent) == 4'h0)
        else $error("sequence ended before final bandwidth");
    AST_IDLE_FINAL: assert property (!fast_active |-> bw_exponent == 4'h0)
        else $error("widened bandwidth while no sequence runs");
    AST_OFS_SUM: assert property ($past(rstn) |-> fb_offset_sum == $past(sum_exp))
        else $error("feedback offset sum wrong");
    // Main scenarios reached
    COV_START: cover property ($rose(fast_active));
    COV_STEP: cover property (fast_active && $changed(bw_exponent));
    COV_END: cover property ($fell(fast_active) && !$past(acq_enter));
endmodule : fac_ctrl_monitor
bind fac_ctrl fac_ctrl_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_fac_ctrl_monitor (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .phase_lock(phase_lock), .acq_enter(acq_enter), .acq_from_freerun(acq_from_freerun),
    .acq_from_holdover(acq_from_holdover), .outputs_toggling(outputs_toggling),
    .skew_offset(skew_offset), .delay_comp_offset(delay_comp_offset),
    .bw_exponent(bw_exponent), .fast_active(fast_active), .fb_offset_sum(fb_offset_sum));
`default_nettype wire

/* dv/fac_loop_model.sv */
// Purpose: Lock detector stand-in facing the controller
// Assumes: Same clock as the controller
// Notes: Lock returns five clocks after every bandwidth change
`timescale 1ns/100ps
`default_nettype none
module fac_loop_model (
    input wire logic clk,
    input wire logic rstn,
    input wire logic lock_en,
    input wire logic chatter,
    input wire logic [fac_pkg::EXP_W-1:0] bw_exponent,
    output logic phase_lock
);
    logic [1:0] age_r;
    logic [3:0] ph_r;
    logic [fac_pkg::EXP_W-1:0] bw_seen_r;
    ////////////////////////////////////////////////////////////////////
    // Chatter drops lock 8 of every 16 clocks, too short to settle 10 ms
    always_ff @(posedge clk) begin
        if (!rstn) begin
            age_r <= 2'h0;
            ph_r <= 4'h0;
            bw_seen_r <= 4'h0;
            phase_lock <= 1'b0;
        end else begin
            bw_seen_r <= bw_exponent;
            ph_r <= ph_r + 4'h1;
            age_r <= (bw_exponent != bw_seen_r) ? 2'h0 : age_r + {1'b0, age_r != 2'h3};
            phase_lock <= lock_en && age_r == 2'h3 && !(chatter && ph_r[3]);
        end
    end
endmodule : fac_loop_model
`default_nettype wire

/* dv/tb_top.sv */
// Purpose: Self-checking bench for the fast acquisition controller
// Assumes: TICK_CYCLES cut to 4, so 1 ms is four clocks
// Notes: Register cases and triggers run from tables
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int TICK = 4;
    typedef struct packed {logic [15:0] a; logic [7:0] w; logic [7:0] r;} fac_row_s;
    typedef struct packed {logic [3:0] trig; logic fr; logic ho; logic tg; logic fast;} fac_trig_s;
    localparam fac_row_s ROWS [13] = '{'{16'h1015, 8'h08, 8'h08}, '{16'h1016, 8'hDB, 8'hDB},
        '{16'h1017, 8'hFE, 8'hFE}, '{16'h1018, 8'hFF, 8'hFF}, '{16'h1019, 8'hFF, 8'hFF},
        '{16'h2106, 8'hFF, 8'h0F}, '{16'h0116, 8'hFF, 8'h0F}, '{16'h0117, 8'hFF, 8'h7F},
        '{16'h2107, 8'h08, 8'h00}, '{16'h200D, 8'h0C, 8'h00}, '{16'h3102, 8'hFF, 8'h00},
        '{16'h3012, 8'hFF, 8'h00}, '{16'h1234, 8'hFF, 8'h00}};
    localparam fac_trig_s TRIGS [9] = '{
        '{4'h1, 1'b1, 1'b0, 1'b1, 1'b1}, '{4'h1, 1'b0, 1'b1, 1'b1, 1'b0},
        '{4'h2, 1'b0, 1'b1, 1'b1, 1'b1}, '{4'h2, 1'b1, 1'b0, 1'b1, 1'b0},
        '{4'h8, 1'b0, 1'b0, 1'b0, 1'b1}, '{4'h8, 1'b0, 1'b0, 1'b1, 1'b0},
        '{4'h4, 1'b0, 1'b0, 1'b1, 1'b1}, '{4'h6, 1'b1, 1'b0, 1'b1, 1'b1},
        '{4'h3, 1'b0, 1'b0, 1'b1, 1'b0}};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [fac_pkg::ADDR_W-1:0] addr = '0;
    logic [fac_pkg::DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic acq_enter = 1'b0;
    logic acq_from_freerun = 1'b0;
    logic acq_from_holdover = 1'b0;
    logic outputs_toggling = 1'b1;
    logic [fac_pkg::OFS_W-1:0] skew_offset = 40'h00_0000_03E8;
    logic [fac_pkg::OFS_W-1:0] delay_comp_offset = 40'hFF_FFFF_FFFB;
    logic lock_en = 1'b1;
    logic chatter = 1'b0;
    logic [fac_pkg::DATA_W-1:0] rdata;
    logic phase_lock;
    logic [fac_pkg::EXP_W-1:0] bw_exponent;
    logic fast_active;
    logic [fac_pkg::SUM_W-1:0] fb_offset_sum;
    int miscompares = 0;
    int check_count = 0;
    ////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;
    fac_ctrl #(.TICK_CYCLES(TICK)) i_fac_ctrl (.clk(clk), .rstn(rstn), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .phase_lock(phase_lock),
        .acq_enter(acq_enter), .acq_from_freerun(acq_from_freerun),
        .acq_from_holdover(acq_from_holdover), .outputs_toggling(outputs_toggling),
        .skew_offset(skew_offset), .delay_comp_offset(delay_comp_offset),
        .bw_exponent(bw_exponent), .fast_active(fast_active), .fb_offset_sum(fb_offset_sum));
    fac_loop_model i_fac_loop_model (.clk(clk), .rstn(rstn), .lock_en(lock_en),
        .chatter(chatter), .bw_exponent(bw_exponent), .phase_lock(phase_lock));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Bus cycles: strobe for one clock, data taken one clock later
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
    endtask : rd_reg
    task automatic acq(input logic fr, input logic ho);
        @(posedge clk);
        acq_enter <= 1'b1;
        acq_from_freerun <= fr;
        acq_from_holdover <= ho;
        @(posedge clk);
        acq_enter <= 1'b0;
    endtask : acq
    // Bounded wait for the sequence to end, n counts clocks
    task automatic wait_idle(input int lim, output int n);
        n = 0;
        @(negedge clk);
        while (fast_active !== 1'b0) begin
            if (n == lim) begin
                miscompares++;
                end_of_test();
            end else begin
                @(negedge clk);
                n++;
            end
        end
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] d;
        int n;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        acq(1'b0, 1'b0);
        @(negedge clk);
        chk(fast_active, 1'b0);
        // Reset values, access kinds, unmapped place
        foreach (ROWS[i]) begin
            rd_reg(ROWS[i].a, d);
            chk(d, 8'h00);
            wr_reg(ROWS[i].a, ROWS[i].w);
            rd_reg(ROWS[i].a, d);
            chk(d, ROWS[i].r);
        end
        chk(fb_offset_sum, 42'h3FF_FFFE_DEEB);
        for (int i = 2; i < 5; i++) wr_reg(fac_pkg::A_PHASE_OFS_LO + 16'(i), 8'h00);
        // Sum lags the last byte write by one clock
        repeat (2) @(negedge clk);
        chk(fb_offset_sum, 42'h000_0000_DEEB);
        // Steady lock, trigger free, excess 3, settle 1 ms, timeout 10 ms
        wr_reg(fac_pkg::A_TRIG_SEL, 8'h00);
        wr_reg(fac_pkg::A_PROF_EXCESS, 8'h03);
        wr_reg(fac_pkg::A_PROF_TIMING, 8'h00);
        acq(1'b0, 1'b0);
        @(negedge clk);
        chk({fast_active, bw_exponent}, 5'h13);
        rd_reg(fac_pkg::A_EVT_STAT, d);
        chk(d, 8'h04);
        wait_idle(2000, n);
        rd_reg(fac_pkg::A_LOOP_STAT2, d);
        chk(d, 8'h20);
        rd_reg(fac_pkg::A_EVT_STAT, d);
        chk(d, 8'h0C);
        // First-acquisition trigger refused once complete is set
        wr_reg(fac_pkg::A_TRIG_SEL, 8'h04);
        acq(1'b0, 1'b0);
        @(negedge clk);
        chk(fast_active, 1'b0);
        wr_reg(fac_pkg::A_CMPL_CLR, 8'h08);
        rd_reg(fac_pkg::A_LOOP_STAT2, d);
        chk(d, 8'h00);
        wr_reg(fac_pkg::A_EVT_CLR, 8'h0C);
        rd_reg(fac_pkg::A_EVT_STAT, d);
        chk(d, 8'h00);
        // Chattering lock: every step must time out after 50 ms
        wr_reg(fac_pkg::A_TRIG_SEL, 8'h00);
        wr_reg(fac_pkg::A_PROF_TIMING, 8'h11);
        chatter <= 1'b1;
        acq(1'b0, 1'b0);
        wait_idle(4000, n);
        chk(n >= 4 * 49 * TICK && n <= 4 * 52 * TICK, 1'b1);
        rd_reg(fac_pkg::A_LOOP_STAT2, d);
        chk(d, 8'h00);
        // Trigger selections, any met condition starts fast
        foreach (TRIGS[i]) begin
            wr_reg(fac_pkg::A_TRIG_SEL, {4'h0, TRIGS[i].trig});
            outputs_toggling <= TRIGS[i].tg;
            acq(TRIGS[i].fr, TRIGS[i].ho);
            @(negedge clk);
            chk(fast_active, TRIGS[i].fast);
        end
        // Reset in mid-sequence returns everything to idle
        wr_reg(fac_pkg::A_TRIG_SEL, 8'h00);
        acq(1'b0, 1'b0);
        repeat (5) @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({fast_active, bw_exponent}, 5'h00);
        rd_reg(fac_pkg::A_PROF_EXCESS, d);
        chk(d, 8'h00);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
